// *** dual_uart_pkg.sv ***
// Shared constants and types for the two-channel serial and modem pin block.
// Assumes a 25 MHz system clock and an AHB-Lite register bus with word access.
package dual_uart_pkg;

  // ****************************************************************
  // Clock and reset timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RESET_MIN_NS = 40;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Register map, byte offset is channel * 0x20 plus index * 4
  // ****************************************************************
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CH_SEL_BIT = 5;
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_MCR = 3'h1;
  localparam logic [2:0] IDX_FEATURE_CONTROL_REG = 3'h2;
  localparam logic [2:0] IDX_EFR = 3'h3;
  localparam logic [2:0] IDX_ENHANCED_MODE_SELECT_REG = 3'h4;
  localparam logic [2:0] IDX_IER = 3'h5;
  localparam logic [2:0] IDX_STAT = 3'h6;
  localparam logic [2:0] IDX_DIV = 3'h7;
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0001;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned MCR_DTR_BIT = 0;
  localparam int unsigned MCR_RTS_BIT = 1;
  localparam int unsigned MCR_OUT2_BIT = 3;
  localparam int unsigned MCR_IR_BIT = 6;
  localparam int unsigned FEATURE_CONTROL_REG_IRINV_BIT = 2;
  localparam int unsigned FEATURE_CONTROL_REG_HDX_BIT = 3;
  localparam int unsigned EFR_ARTS_BIT = 6;
  localparam int unsigned EFR_ACTS_BIT = 7;
  localparam int unsigned ENHANCED_MODE_SELECT_REG_POL_BIT = 3;
  localparam int unsigned IER_RX_BIT = 0;
  localparam int unsigned IER_CTS_BIT = 7;
  localparam int unsigned ST_RXRDY = 0;
  localparam int unsigned ST_TXBUSY = 1;
  localparam int unsigned ST_OVR = 2;
  localparam int unsigned ST_CTSCHG = 3;
  localparam int unsigned ST_CTS = 4;
  localparam int unsigned ST_DSR = 5;
  localparam int unsigned ST_RI = 6;
  localparam int unsigned ST_CD = 7;

  // ****************************************************************
  // Input pin order in the synchroniser bus
  // ****************************************************************
  localparam int unsigned NUM_PINS = 5;
  localparam int unsigned PIN_RX = 0;
  localparam int unsigned PIN_CTS = 1;
  localparam int unsigned PIN_DSR = 2;
  localparam int unsigned PIN_CD = 3;
  localparam int unsigned PIN_RI = 4;

  // ****************************************************************
  // Bit timing in sample ticks, sixteen ticks to a bit
  // ****************************************************************
  localparam logic [3:0] LAST_TICK = 4'hF;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [4:0] IR_HOLD_TICKS = 5'h10;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] LAST_TX_BIT = 4'h9;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
  typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000} rx_state_t;

  typedef struct packed {
    logic [7:0] modem_control_reg;
    logic [7:0] feature_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] enhanced_mode_select_reg;
    logic [7:0] interrupt_enable_reg;
    logic [15:0] div;
    logic [15:0] pre;
    logic [7:0] thr;
    logic thr_full;
    tx_state_t tx_st;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_tick;
    rx_state_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [3:0] rx_tick;
    logic [7:0] receive_holding_reg;
    logic rx_rdy;
    logic ovr;
    logic cts_prev;
    logic cts_chg;
    logic [4:0] ir_hold;
    logic txd;
    logic rts_n;
    logic dtr_n;
    logic op2_n;
    logic irq;
    logic irq_oe;
    logic rxrdy_n;
  } chan_t;

  typedef struct packed {
    logic hready;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [5:0] wr_addr;
    chan_t [NUM_CH-1:0] ch;
  } state_t;

endpackage

// *** pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous input pins.
// Assumes the pins are static for at least two clock periods per level.
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned WIDTH = 5
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t r_ff;
  sync_t nxt_r;

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  // two flops first.
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = pins_in;
    nxt_r.s2 = r_ff.s1;
  end

  // Idle level of every pin is high in NRZ mode, the reset default, so both stages reset high.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_ff <= '1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pins_out = r_ff.s2;

endmodule

// *** dual_uart_pins.sv ***
// Two-channel UART serial and modem pin logic behind an AHB-Lite register slave.
// Assumes one 25 MHz clock, an active-low asynchronous reset and word-only single transfers.
// Operation
// - Each channel drives an active-low receiver-ready pin from its receive holding status.
// - With infrared select clear, transmit and receive use plain NRZ signalling.
// - In NRZ mode the transmit pin is high in reset and when idle.
// - With infrared select set, data pass through the IrDA encoder and decoder.
// - In infrared mode the transmit pin rests low with nothing to send.
// - Infrared receive idles low; a polarity bit inverts it before decoding.
// - Automatic half-duplex makes request-to-send steer the line driver, polarity selectable.
// - Clear-to-send gates transmission under auto flow control; its change may interrupt.
// - Modem control bit three set drives the interrupt pin and output port low.
// - Bit three clear, the reset default, floats interrupt and drives output port high.
// - Set-ready, carrier-detect and ring inputs are status only.
// - Terminal-ready is a software-driven active-low output.
// - Without auto flow control or half-duplex, request-to-send is a software-driven output.
// - Both channels have identical independent pins and serial logic.
// - Reset clears registers except the divisor, which loads one; outputs go inactive, transmit is high and receive ignored.
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
module dual_uart_pins
  import dual_uart_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic serial_in_a_in,
  input wire logic clear_send_a_n_in,
  input wire logic set_ready_a_n_in,
  input wire logic carrier_detect_a_n_in,
  input wire logic ring_indicate_a_n_in,
  output logic serial_out_a_out,
  output logic request_send_a_n_out,
  output logic terminal_ready_a_n_out,
  output logic out_port2_a_n_out,
  output logic irq_out_a_out,
  output logic irq_oe_a_out,
  output logic rx_ready_a_n_out,
  input wire logic serial_in_b_in,
  input wire logic clear_send_b_n_in,
  input wire logic set_ready_b_n_in,
  input wire logic carrier_detect_b_n_in,
  input wire logic ring_indicate_b_n_in,
  output logic serial_out_b_out,
  output logic request_send_b_n_out,
  output logic terminal_ready_b_n_out,
  output logic out_port2_b_n_out,
  output logic irq_out_b_out,
  output logic irq_oe_b_out,
  output logic rx_ready_b_n_out
);

  state_t r_ff;
  state_t nxt_r;
  logic [NUM_PINS-1:0] pin_raw [NUM_CH];
  logic [NUM_PINS-1:0] pin_syn [NUM_CH];
  logic acc;
  logic tick;
  logic rx_nrz;
  logic ir_in;
  logic cts_ok;
  logic [7:0] rd;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  assign pin_raw[0] = {ring_indicate_a_n_in, carrier_detect_a_n_in, set_ready_a_n_in,
                       clear_send_a_n_in, serial_in_a_in};
  assign pin_raw[1] = {ring_indicate_b_n_in, carrier_detect_b_n_in, set_ready_b_n_in,
                       clear_send_b_n_in, serial_in_b_in};

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      pin_sync #(.WIDTH(NUM_PINS)) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(pin_raw[g]),
        .pins_out(pin_syn[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Bus slave and channel logic
  // ****************************************************************
  always_comb begin
    nxt_r = r_ff;
    acc = hsel_in && htrans_in[1] && hready_in;
    tick = 1'b0;
    rx_nrz = 1'b1;
    ir_in = 1'b0;
    cts_ok = 1'b0;
    rd = 8'h00;
    nxt_r.hready = 1'b1;
    nxt_r.wr_pend = acc && hwrite_in && (haddr_in[31:6] == 26'h0);
    nxt_r.wr_addr = haddr_in[5:0];
    if (acc && !hwrite_in) begin
      nxt_r.hrdata = 32'h0000_0000;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // Data phase of a write lands here.
      if (r_ff.wr_pend && (r_ff.wr_addr[CH_SEL_BIT] == c[0])) begin
        case (r_ff.wr_addr[4:2])
          IDX_DATA: begin
            nxt_r.ch[c].thr = hwdata_in[7:0];
            nxt_r.ch[c].thr_full = 1'b1;
          end
          IDX_MCR: nxt_r.ch[c].modem_control_reg = hwdata_in[7:0];
          IDX_FEATURE_CONTROL_REG: nxt_r.ch[c].feature_control_reg = hwdata_in[7:0];
          IDX_EFR: nxt_r.ch[c].enhanced_feature_reg = hwdata_in[7:0];
          IDX_ENHANCED_MODE_SELECT_REG: nxt_r.ch[c].enhanced_mode_select_reg = hwdata_in[7:0];
          IDX_IER: nxt_r.ch[c].interrupt_enable_reg = hwdata_in[7:0];
          IDX_DIV: nxt_r.ch[c].div = hwdata_in[15:0];
          default: begin
          end
        endcase
      end
      // Reads see the result of a write in the same cycle; reads clear flags before new sets.
      if (acc && !hwrite_in && (haddr_in[31:6] == 26'h0) && (haddr_in[CH_SEL_BIT] == c[0])) begin
        case (haddr_in[4:2])
          IDX_DATA: begin
            rd = nxt_r.ch[c].receive_holding_reg;
            nxt_r.ch[c].rx_rdy = 1'b0;
          end
          IDX_MCR: rd = nxt_r.ch[c].modem_control_reg;
          IDX_FEATURE_CONTROL_REG: rd = nxt_r.ch[c].feature_control_reg;
          IDX_EFR: rd = nxt_r.ch[c].enhanced_feature_reg;
          IDX_ENHANCED_MODE_SELECT_REG: rd = nxt_r.ch[c].enhanced_mode_select_reg;
          IDX_IER: rd = nxt_r.ch[c].interrupt_enable_reg;
          IDX_STAT: begin
            rd[ST_RXRDY] = r_ff.ch[c].rx_rdy;
            rd[ST_TXBUSY] = (r_ff.ch[c].tx_st == TX_SEND) || r_ff.ch[c].thr_full;
            rd[ST_OVR] = r_ff.ch[c].ovr;
            rd[ST_CTSCHG] = r_ff.ch[c].cts_chg;
            rd[ST_CTS] = !pin_syn[c][PIN_CTS];
            rd[ST_DSR] = !pin_syn[c][PIN_DSR];
            rd[ST_RI] = !pin_syn[c][PIN_RI];
            rd[ST_CD] = !pin_syn[c][PIN_CD];
            nxt_r.ch[c].ovr = 1'b0;
            nxt_r.ch[c].cts_chg = 1'b0;
          end
          IDX_DIV: rd = 8'h00;
          default: rd = 8'h00;
        endcase
        if (haddr_in[4:2] == IDX_DIV) begin
          nxt_r.hrdata = {16'h0000, nxt_r.ch[c].div};
        end else begin
          nxt_r.hrdata = {24'h00_0000, rd};
        end
      end
      // Sixteen sample ticks to a bit.
      if (r_ff.ch[c].pre == 16'h0000) begin
        tick = 1'b1;
        nxt_r.ch[c].pre = r_ff.ch[c].div;
      end else begin
        tick = 1'b0;
        nxt_r.ch[c].pre = r_ff.ch[c].pre - 16'h0001;
      end
      cts_ok = !r_ff.ch[c].enhanced_feature_reg[EFR_ACTS_BIT] || !pin_syn[c][PIN_CTS];
      case (r_ff.ch[c].tx_st)
        TX_IDLE: begin
          if (nxt_r.ch[c].thr_full && r_ff.ch[c].thr_full && cts_ok) begin
            nxt_r.ch[c].tx_sh = {1'b1, r_ff.ch[c].thr, 1'b0};
            nxt_r.ch[c].thr_full = 1'b0;
            nxt_r.ch[c].tx_bit = 4'h0;
            nxt_r.ch[c].tx_tick = 4'h0;
            nxt_r.ch[c].tx_st = TX_SEND;
          end
        end
        TX_SEND: begin
          if (tick) begin
            nxt_r.ch[c].tx_tick = r_ff.ch[c].tx_tick + 4'h1;
            if (r_ff.ch[c].tx_tick == LAST_TICK) begin
              nxt_r.ch[c].tx_sh = {1'b1, r_ff.ch[c].tx_sh[9:1]};
              nxt_r.ch[c].tx_bit = r_ff.ch[c].tx_bit + 4'h1;
              if (r_ff.ch[c].tx_bit == LAST_TX_BIT) begin
                nxt_r.ch[c].tx_st = TX_IDLE;
              end
            end
          end
        end
        default: nxt_r.ch[c].tx_st = TX_IDLE;
      endcase
      ir_in = pin_syn[c][PIN_RX] ^ r_ff.ch[c].feature_control_reg[FEATURE_CONTROL_REG_IRINV_BIT];
      // stretch each pulse into a low bit cell.
      if (ir_in) begin
        nxt_r.ch[c].ir_hold = IR_HOLD_TICKS;
      end else if (tick && (r_ff.ch[c].ir_hold != 5'h00)) begin
        nxt_r.ch[c].ir_hold = r_ff.ch[c].ir_hold - 5'h01;
      end
      if (r_ff.ch[c].modem_control_reg[MCR_IR_BIT]) begin
        rx_nrz = (r_ff.ch[c].ir_hold == 5'h00);
      end else begin
        rx_nrz = pin_syn[c][PIN_RX];
      end
      // start bit is a low after idle high.
      if (tick) begin
        case (r_ff.ch[c].rx_st)
          RX_IDLE: begin
            if (!rx_nrz) begin
              nxt_r.ch[c].rx_tick = 4'h0;
              nxt_r.ch[c].rx_st = RX_START;
            end
          end
          RX_START: begin
            nxt_r.ch[c].rx_tick = r_ff.ch[c].rx_tick + 4'h1;
            if (r_ff.ch[c].rx_tick == MID_TICK) begin
              nxt_r.ch[c].rx_tick = 4'h0;
              nxt_r.ch[c].rx_bit = 4'h0;
              nxt_r.ch[c].rx_st = rx_nrz ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            nxt_r.ch[c].rx_tick = r_ff.ch[c].rx_tick + 4'h1;
            if (r_ff.ch[c].rx_tick == LAST_TICK) begin
              nxt_r.ch[c].rx_sh = {rx_nrz, r_ff.ch[c].rx_sh[7:1]};
              nxt_r.ch[c].rx_bit = r_ff.ch[c].rx_bit + 4'h1;
              if (r_ff.ch[c].rx_bit == LAST_DATA_BIT) begin
                nxt_r.ch[c].rx_st = RX_STOP;
              end
            end
          end
          RX_STOP: begin
            nxt_r.ch[c].rx_tick = r_ff.ch[c].rx_tick + 4'h1;
            if (r_ff.ch[c].rx_tick == LAST_TICK) begin
              nxt_r.ch[c].rx_st = RX_IDLE;
              if (rx_nrz) begin
                nxt_r.ch[c].receive_holding_reg = r_ff.ch[c].rx_sh;
                nxt_r.ch[c].ovr = r_ff.ch[c].ovr || r_ff.ch[c].rx_rdy;
                nxt_r.ch[c].rx_rdy = 1'b1;
              end
            end
          end
          default: nxt_r.ch[c].rx_st = RX_IDLE;
        endcase
      end
      // clear-to-send change flag, set wins over read clear.
      nxt_r.ch[c].cts_prev = pin_syn[c][PIN_CTS];
      if (pin_syn[c][PIN_CTS] != r_ff.ch[c].cts_prev) begin
        nxt_r.ch[c].cts_chg = 1'b1;
      end
      // Pin outputs from the settled next state.
      if (nxt_r.ch[c].modem_control_reg[MCR_IR_BIT]) begin
        // short pulse on each zero bit, rest low.
        nxt_r.ch[c].txd = (nxt_r.ch[c].tx_st == TX_SEND) && !nxt_r.ch[c].tx_sh[0] &&
                          (nxt_r.ch[c].tx_tick < IR_PULSE_TICKS);
      end else begin
        // high unless a zero bit is on the line.
        nxt_r.ch[c].txd = (nxt_r.ch[c].tx_st != TX_SEND) || nxt_r.ch[c].tx_sh[0];
      end
      if (nxt_r.ch[c].feature_control_reg[FEATURE_CONTROL_REG_HDX_BIT]) begin
        nxt_r.ch[c].rts_n = (nxt_r.ch[c].tx_st == TX_SEND) ? nxt_r.ch[c].enhanced_mode_select_reg[ENHANCED_MODE_SELECT_REG_POL_BIT] :
                            !nxt_r.ch[c].enhanced_mode_select_reg[ENHANCED_MODE_SELECT_REG_POL_BIT];
      end else if (nxt_r.ch[c].enhanced_feature_reg[EFR_ARTS_BIT]) begin
        // auto hold-off only while software asserts the pin.
        nxt_r.ch[c].rts_n = !nxt_r.ch[c].modem_control_reg[MCR_RTS_BIT] || nxt_r.ch[c].rx_rdy;
      end else begin
        nxt_r.ch[c].rts_n = !nxt_r.ch[c].modem_control_reg[MCR_RTS_BIT];
      end
      nxt_r.ch[c].dtr_n = !nxt_r.ch[c].modem_control_reg[MCR_DTR_BIT];
      // enable drives irq and port low; disable floats irq and port high.
      nxt_r.ch[c].op2_n = !nxt_r.ch[c].modem_control_reg[MCR_OUT2_BIT];
      nxt_r.ch[c].irq_oe = nxt_r.ch[c].modem_control_reg[MCR_OUT2_BIT];
      nxt_r.ch[c].irq = (nxt_r.ch[c].interrupt_enable_reg[IER_CTS_BIT] && nxt_r.ch[c].cts_chg) ||
                        (nxt_r.ch[c].interrupt_enable_reg[IER_RX_BIT] && nxt_r.ch[c].rx_rdy);
      nxt_r.ch[c].rxrdy_n = !nxt_r.ch[c].rx_rdy;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // reset clears registers except the divisor, which loads one; outputs reset to their inactive levels.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_ff <= '0;
      r_ff.hready <= 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        r_ff.ch[c].modem_control_reg <= REG8_RESET;
        r_ff.ch[c].div <= DIV_RESET;
        r_ff.ch[c].tx_st <= TX_IDLE;
        r_ff.ch[c].rx_st <= RX_IDLE;
        r_ff.ch[c].cts_prev <= 1'b1;
        r_ff.ch[c].txd <= 1'b1;
        r_ff.ch[c].rts_n <= 1'b1;
        r_ff.ch[c].dtr_n <= 1'b1;
        r_ff.ch[c].op2_n <= 1'b1;
        r_ff.ch[c].rxrdy_n <= 1'b1;
      end
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign hrdata_out = r_ff.hrdata;
  assign hreadyout_out = r_ff.hready;
  assign hresp_out = 1'b0;
  assign serial_out_a_out = r_ff.ch[0].txd;
  assign request_send_a_n_out = r_ff.ch[0].rts_n;
  assign terminal_ready_a_n_out = r_ff.ch[0].dtr_n;
  assign out_port2_a_n_out = r_ff.ch[0].op2_n;
  assign irq_out_a_out = r_ff.ch[0].irq;
  assign irq_oe_a_out = r_ff.ch[0].irq_oe;
  assign rx_ready_a_n_out = r_ff.ch[0].rxrdy_n;
  assign serial_out_b_out = r_ff.ch[1].txd;
  assign request_send_b_n_out = r_ff.ch[1].rts_n;
  assign terminal_ready_b_n_out = r_ff.ch[1].dtr_n;
  assign out_port2_b_n_out = r_ff.ch[1].op2_n;
  assign irq_out_b_out = r_ff.ch[1].irq;
  assign irq_oe_b_out = r_ff.ch[1].irq_oe;
  assign rx_ready_b_n_out = r_ff.ch[1].rxrdy_n;

  // ****************************************************************
  // Assertions on channel A
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_tx_load;
    (r_ff.ch[0].tx_st == TX_IDLE) ##1 (r_ff.ch[0].tx_st == TX_SEND);
  endsequence

  sequence s_nrz_mode;
    !r_ff.ch[0].modem_control_reg[MCR_IR_BIT];
  endsequence

  a_rx_ready_pin: assert property (rx_ready_a_n_out == !r_ff.ch[0].rx_rdy)
    else $error("receiver ready pin disagrees with holding status");
  a_nrz_idle_high: assert property ((s_nrz_mode and (r_ff.ch[0].tx_st == TX_IDLE)) |-> serial_out_a_out)
    else $error("NRZ transmit not high while idle");
  // NRZ start bit follows a load.
  a_nrz_start_low: assert property ((s_tx_load and s_nrz_mode) |-> !serial_out_a_out)
    else $error("NRZ start bit missing after load");
  a_ir_idle_low: assert property ((r_ff.ch[0].modem_control_reg[MCR_IR_BIT] && (r_ff.ch[0].tx_st == TX_IDLE)) |-> !serial_out_a_out)
    else $error("infrared transmit not low while idle");
  a_ir_pulse_width: assert property ((r_ff.ch[0].modem_control_reg[MCR_IR_BIT] && serial_out_a_out) |-> (r_ff.ch[0].tx_tick < 4'h3))
    else $error("infrared pulse longer than three ticks");
  // output port and irq enable move together.
  a_op2_irq_pair: assert property (out_port2_a_n_out == !irq_oe_a_out)
    else $error("output port two and irq enable disagree");
  // cleared enable floats irq on the next edge.
  a_irq_float: assert property ((r_ff.wr_pend && (r_ff.wr_addr == 6'h04) && !hwdata_in[3]) |=> (!irq_oe_a_out && out_port2_a_n_out))
    else $error("irq not floated after enable cleared");
  // auto flow control holds the transmitter.
  a_cts_gate: assert property ((r_ff.ch[0].enhanced_feature_reg[EFR_ACTS_BIT] && pin_syn[0][PIN_CTS] && (r_ff.ch[0].tx_st == TX_IDLE)) |=> (r_ff.ch[0].tx_st == TX_IDLE))
    else $error("transmitter started while clear-to-send negated");
  a_half_duplex: assert property ((r_ff.ch[0].feature_control_reg[FEATURE_CONTROL_REG_HDX_BIT] && (r_ff.ch[0].tx_st == TX_SEND)) |-> (request_send_a_n_out == r_ff.ch[0].enhanced_mode_select_reg[ENHANCED_MODE_SELECT_REG_POL_BIT]))
    else $error("direction pin wrong during transmission");
  a_rts_manual: assert property ((!r_ff.ch[0].feature_control_reg[FEATURE_CONTROL_REG_HDX_BIT] && !r_ff.ch[0].enhanced_feature_reg[EFR_ARTS_BIT]) |-> (request_send_a_n_out == !r_ff.ch[0].modem_control_reg[MCR_RTS_BIT]))
    else $error("request-to-send not following software");
  a_dtr_follow: assert property (terminal_ready_a_n_out == !r_ff.ch[0].modem_control_reg[MCR_DTR_BIT])
    else $error("terminal ready not following software");
  // pulse turns into a low cell.
  a_ir_decode: assert property ((r_ff.ch[0].modem_control_reg[MCR_IR_BIT] && (pin_syn[0][PIN_RX] ^ r_ff.ch[0].feature_control_reg[FEATURE_CONTROL_REG_IRINV_BIT])) |=> (r_ff.ch[0].ir_hold == 5'h10))
    else $error("infrared pulse not stretched");

endmodule

// *** uart_far_end.sv ***
// Far-end serial transceiver model for one channel.
// Assumes BIT_CYC clocks per bit, matching the divisor left at its reset value.
`timescale 1ns/100ps
module uart_far_end #(
  parameter int BIT_CYC = 32
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'h1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
  endtask
  task automatic grab_byte(output logic [7:0] b);
    while (line_in !== 1'h0) @(posedge clk_in);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      b[i] = line_in;
      repeat (BIT_CYC) @(posedge clk_in);
    end
  endtask
endmodule

// *** dual_uart_serial_modem_pins_tb_top.sv ***
// Bench for the two-channel serial and modem pin block.
// Assumes the far-end model on channel A and the divisor at its reset value.
`timescale 1ns/100ps
module dual_uart_serial_modem_pins_tb_top;
  logic clk_in = 0, rst_b_in = 0, hsel_in = 0, hwrite_in = 0, hready_in, hreadyout_out, hresp_out;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, rd;
  logic [1:0] htrans_in = 0;
  logic [2:0] hsize_in = 3'h2;
  logic [7:0] b;
  logic serial_in_a_in, serial_in_b_in = 1, clear_send_a_n_in = 1, set_ready_a_n_in = 1;
  logic carrier_detect_a_n_in = 1, ring_indicate_a_n_in = 1, clear_send_b_n_in = 1, set_ready_b_n_in = 1;
  logic carrier_detect_b_n_in = 1, ring_indicate_b_n_in = 1, serial_out_a_out, request_send_a_n_out;
  logic terminal_ready_a_n_out, out_port2_a_n_out, irq_out_a_out, irq_oe_a_out, rx_ready_a_n_out;
  logic serial_out_b_out, request_send_b_n_out, terminal_ready_b_n_out, out_port2_b_n_out;
  logic irq_out_b_out, irq_oe_b_out, rx_ready_b_n_out;
  int n_errors = 0, compares = 0;
  assign hready_in = hreadyout_out;
  always #20 clk_in = ~clk_in;
  dual_uart_pins DUT (.*);
  uart_far_end #(.BIT_CYC(32)) P (.clk_in(clk_in), .line_in(serial_out_a_out), .line_out(serial_in_a_in));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel_in <= 1'h1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    @(posedge clk_in);
    while (hreadyout_out !== 1'h1) @(posedge clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    @(posedge clk_in);
    while (hreadyout_out !== 1'h1) @(posedge clk_in);
    rd = hrdata_out;
  endtask
  task automatic pins(input logic [5:0] e);
    chk("pins a", {26'h0, e}, {26'h0, serial_out_a_out, request_send_a_n_out, terminal_ready_a_n_out,
      out_port2_a_n_out, irq_oe_a_out, rx_ready_a_n_out});
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    pins(6'h3D);
    chk("hresp", 32'h0, hresp_out);
    chk("irq a", 32'h0, irq_out_a_out);
    chk("pins b", 32'h3D, {26'h0, serial_out_b_out, request_send_b_n_out, terminal_ready_b_n_out,
      out_port2_b_n_out, irq_oe_b_out, rx_ready_b_n_out});
    chk("irq b", 32'h0, irq_out_b_out);
    bus(1'h0, 32'h1C, 32'h0);
    chk("div", 32'h1, rd);
    bus(1'h0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_modem;
    bus(1'h1, 32'h04, 32'h0B);
    @(posedge clk_in);
    pins(6'h23);
    chk("op2 b", 32'h1, out_port2_b_n_out);
    bus(1'h1, 32'h04, 32'h00);
    @(posedge clk_in);
    pins(6'h3D);
  endtask
  task automatic t_tx;
    bus(1'h1, 32'h00, 32'hA5);
    P.grab_byte(b);
    chk("tx byte", 32'hA5, {24'h0, b});
    chk("tx b idle", 32'h1, serial_out_b_out);
    repeat (80) @(posedge clk_in);
    chk("tx idle", 32'h1, serial_out_a_out);
  endtask
  task automatic t_rx;
    P.send_byte(8'h3C);
    repeat (8) @(posedge clk_in);
    chk("rx ready", 32'h0, rx_ready_a_n_out);
    bus(1'h0, 32'h00, 32'h0);
    chk("rx data", 32'h3C, rd);
    @(posedge clk_in);
    chk("rx ready clr", 32'h1, rx_ready_a_n_out);
  endtask
  task automatic t_flow;
    bus(1'h1, 32'h04, 32'h02);
    bus(1'h1, 32'h0C, 32'h40);
    @(posedge clk_in);
    chk("auto rts", 32'h0, request_send_a_n_out);
    bus(1'h1, 32'h0C, 32'hC0);
    bus(1'h1, 32'h00, 32'h5A);
    repeat (8) @(posedge clk_in);
    chk("cts hold", 32'h1, serial_out_a_out);
    clear_send_a_n_in <= 1'h0;
    P.grab_byte(b);
    chk("cts byte", 32'h5A, {24'h0, b});
    repeat (40) @(posedge clk_in);
  endtask
  task automatic t_ir;
    set_ready_a_n_in <= 1'h0;
    repeat (4) @(posedge clk_in);
    bus(1'h0, 32'h18, 32'h0);
    chk("dsr", 32'h20, rd & 32'h20);
    chk("tx unmoved", 32'h1, serial_out_a_out);
    bus(1'h1, 32'h04, 32'h40);
    @(posedge clk_in);
    chk("ir idle", 32'h0, serial_out_a_out);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'h1;
    @(posedge clk_in);
    t_reset;
    t_modem;
    t_tx;
    t_rx;
    t_flow;
    t_ir;
    wrap_up;
  end
  initial begin
    #800000;
    n_errors++;
    wrap_up;
  end
endmodule
